/* rtl/vfct_defs.svh */
`ifndef VFCT_DEFS_SVH
`define VFCT_DEFS_SVH
// register byte offsets
`define VFCT_CTRL_OFS 8'h00
`define VFCT_TRIG_EN_OFS 8'h04
`define VFCT_POS_OFS 8'h08
`define VFCT_STATUS_OFS 8'h0c
`define VFCT_INDEX_OFS 8'h10
`define VFCT_PROGRESS_OFS 8'h14
`define VFCT_CLIP_LEN_OFS 8'h18
`define VFCT_MODE_OFS 8'h1c
// control command bit positions (write pulses)
`define VFCT_CMD_RECORD 0
`define VFCT_CMD_TRIGGER 1
`define VFCT_CMD_PLAY 2
`define VFCT_CMD_STOP 3
`define VFCT_CMD_STEP_BACK 4
`define VFCT_CMD_STEP_FWD 5
`define VFCT_CMD_SAVE 6
`define VFCT_CMD_LOAD 7
`define VFCT_CMD_W 8
// mode register bits
`define VFCT_MODE_HD 0
`define VFCT_MODE_SINGLE 1
// index register field positions
`define VFCT_IDX_CUR_LSB 0
`define VFCT_IDX_TOTAL_LSB 8
`define VFCT_IDX_TRIG_LSB 16
// buffer depth in frames, per line standard
`define VFCT_DEPTH_SD 7'd70
`define VFCT_DEPTH_HD 7'd13
// reset values
`define VFCT_TRIG_EN_RST 12'h000
`define VFCT_POS_RST 7'h00
`define VFCT_CLIP_LEN_RST 7'h01
`define VFCT_RESP_OKAY 2'h0
`define VFCT_RESP_SLVERR 2'h2
`endif

/* rtl/vfct_pkg.sv */
package vfct_pkg;
  // capture engine states
  typedef enum logic [2:0] {
    st_idle,
    st_record,
    st_captured,
    st_playing,
    st_xfer
  } vfct_state_t;
  typedef logic [6:0] vfct_frame_t;
  typedef logic [19:0] vfct_word_t;
endpackage

/* rtl/vfct_trig_detect.sv */
`timescale 1ns/10ps
`include "vfct_defs.svh"
module vfct_trig_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // enables, one per source
  input wire logic [11:0] trig_en,
  // level flags from the receiver
  input wire logic edh_active_picture_flag,
  input wire logic edh_full_field_flag,
  input wire logic link1_luma_crc_err,
  input wire logic link1_chroma_crc_err,
  input wire logic link2_luma_crc_err,
  input wire logic link2_chroma_crc_err,
  input wire logic [15:0] link1_picture_check,
  input wire logic [15:0] link2_picture_check,
  input wire logic link1_luma_anc_err,
  input wire logic link1_chroma_anc_err,
  input wire logic link2_luma_anc_err,
  input wire logic link2_chroma_anc_err,
  // combined event pulse
  output logic trig_event
);
  import vfct_pkg::*;

  // change-sensitive bits: the two error-detection flags
  localparam logic [9:0] CHANGE_MASK = 10'h003;

  typedef struct packed {
    logic primed;
    logic [9:0] flags;
    logic [15:0] chk1;
    logic [15:0] chk2;
    logic event_out;
  } vfct_td_t;

  vfct_td_t q, d;
  logic [9:0] now;
  logic [9:0] hit;
  logic [11:0] src;

  // single-bit sources packed for the loop
  assign now = {link2_chroma_anc_err, link2_luma_anc_err, link1_chroma_anc_err,
                link1_luma_anc_err, link2_chroma_crc_err, link2_luma_crc_err,
                link1_chroma_crc_err, link1_luma_crc_err, edh_full_field_flag,
                edh_active_picture_flag};

  //////////////////////////////////////////////////////////////////////////////
  // per-source detector: change or rising set
  genvar i;
  generate
    for (i = 0; i < 10; i = i + 1)
    begin : g_src
      if (CHANGE_MASK[i])
      begin : g_chg
        assign hit[i] = q.primed && (now[i] != q.flags[i]);
      end
      else
      begin : g_set
        assign hit[i] = now[i] && !q.flags[i];
      end
    end
  endgenerate

  // bit order matches the enable register
  assign src = {hit[9:6],
                q.primed && (link2_picture_check != q.chk2),
                q.primed && (link1_picture_check != q.chk1),
                hit[5:0]};

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    d = q;
    d.primed = 1'b1;
    d.flags = now;
    d.chk1 = link1_picture_check;
    d.chk2 = link2_picture_check;
    d.event_out = |(src & trig_en);
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end

  assign trig_event = q.event_out;

  a_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (trig_en == 12'h000) |=> !trig_event)
    else $error("event from disabled sources");
endmodule // vfct_trig_detect

/* rtl/vfct_xfer.sv */
`timescale 1ns/10ps
module vfct_xfer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // start request
  input wire logic go,
  input wire vfct_pkg::vfct_frame_t count,
  // mover says one frame is done
  input wire logic frame_done,
  // progress
  output logic busy,
  output vfct_pkg::vfct_frame_t done_frames,
  output logic finished
);
  import vfct_pkg::*;

  typedef struct packed {
    logic busy;
    vfct_frame_t idx;
    vfct_frame_t count;
    logic fin;
  } vfct_xf_t;

  vfct_xf_t q, d;

  //////////////////////////////////////////////////////////////////////////////
  // frame counter, finishing pulse on the last frame
  always_comb
  begin
    d = q;
    d.fin = 1'b0;
    if (!q.busy && go)
    begin
      d.busy = 1'b1;
      d.idx = '0;
      d.count = (count == 7'h00) ? 7'h01 : count; // never zero frames
    end
    else if (q.busy && frame_done)
    begin
      d.idx = q.idx + 7'h01;
      if (q.idx + 7'h01 == q.count)
      begin
        d.busy = 1'b0;
        d.fin = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end

  assign busy = q.busy;
  assign done_frames = q.idx;
  assign finished = q.fin;

  a_progress_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (busy && frame_done && !finished) |=> (done_frames == $past(done_frames) + 7'h01))
    else $error("progress did not advance");
endmodule // vfct_xfer

/* rtl/vfct_capture.sv */
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "vfct_defs.svh"
// How it works
// - record frames circularly, 70 SD or 13 HD
// - trigger freezes buffer as captured clip
// - every word of each frame is stored
// - manual trigger while recording ends in captured
// - armed event while recording enters captured
// - position sets frames kept after trigger
// - report filling until buffer fully written
// - report recording while writing incoming stream
// - play loops captured frames, reports playing
// - stop halts playback, holds current frame
// - step moves current index by one
// - expose indexes, flag current equals trigger
// - error-detection triggers fire on flag change
// - line CRC triggers fire when set
// - picture check triggers fire on change
// - ancillary checksum triggers fire when set
// - load refills buffer as navigable clip
// - report save or load progress
module vfct_capture (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // incoming video stream
  input wire vfct_pkg::vfct_word_t vid_data,
  input wire logic vid_valid,
  input wire logic vid_sof,
  input wire logic vid_eof,
  // receiver error flags
  input wire logic edh_active_picture_flag,
  input wire logic edh_full_field_flag,
  input wire logic link1_luma_crc_err,
  input wire logic link1_chroma_crc_err,
  input wire logic link2_luma_crc_err,
  input wire logic link2_chroma_crc_err,
  input wire logic [15:0] link1_picture_check,
  input wire logic [15:0] link2_picture_check,
  input wire logic link1_luma_anc_err,
  input wire logic link1_chroma_anc_err,
  input wire logic link2_luma_anc_err,
  input wire logic link2_chroma_anc_err,
  // frame store write side
  output logic store_we,
  output vfct_pkg::vfct_frame_t store_slot,
  output vfct_pkg::vfct_word_t store_data,
  output logic store_sof,
  // displayed frame
  output vfct_pkg::vfct_frame_t show_slot,
  output logic show_is_trigger,
  // clip_store_folder mover
  output logic xfer_active,
  output logic xfer_is_load,
  output vfct_pkg::vfct_frame_t xfer_slot,
  input wire logic xfer_frame_done
);
  import vfct_pkg::*;

  typedef struct packed {
    vfct_state_t st;
    logic [11:0] trig_en;
    vfct_frame_t pos;
    vfct_frame_t clip_len;
    logic hd;
    logic single;
    vfct_frame_t wr;         // next slot to write
    vfct_frame_t filled;     // frames written, saturating at depth
    vfct_frame_t start;      // oldest slot of the clip
    vfct_frame_t total;
    vfct_frame_t cur;
    vfct_frame_t trig_idx;
    logic trig_pend;
    vfct_frame_t post_left;
    vfct_frame_t tpos;
    logic filling;
    logic at_trig;
    logic we;
    vfct_frame_t slot;
    vfct_word_t data;
    logic sof;
    vfct_frame_t show;
    logic [`VFCT_CMD_W-1:0] cmd;
    logic xs_go;
    logic xs_load;
    vfct_frame_t xs_base;
    vfct_frame_t xs_count;
    vfct_frame_t xslot;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vfct_cap_t;

  vfct_cap_t q, d;
  logic trig_event;       // registered event from detector
  logic xf_busy;          // transfer engine busy
  logic xf_fin;           // transfer finished pulse
  vfct_frame_t xf_done;   // frames moved so far
  vfct_frame_t depth;     // frames in the ring
  logic [31:0] wmask;     // byte enables as bits
  logic [31:0] wm;        // masked write data

  assign depth = q.hd ? `VFCT_DEPTH_HD : `VFCT_DEPTH_SD;

  // ring addition: both operands below depth, so one subtract suffices
  function automatic vfct_frame_t ring_add(input vfct_frame_t a, input vfct_frame_t b,
                                           input vfct_frame_t dep);
    logic [7:0] s;
    s = {1'b0, a} + {1'b0, b};
    ring_add = (s >= {1'b0, dep}) ? 7'(s - {1'b0, dep}) : s[6:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // submodules
  vfct_trig_detect u_trig (
    .aclk(aclk),
    .aresetn(aresetn),
    .trig_en(q.trig_en),
    .edh_active_picture_flag(edh_active_picture_flag),
    .edh_full_field_flag(edh_full_field_flag),
    .link1_luma_crc_err(link1_luma_crc_err),
    .link1_chroma_crc_err(link1_chroma_crc_err),
    .link2_luma_crc_err(link2_luma_crc_err),
    .link2_chroma_crc_err(link2_chroma_crc_err),
    .link1_picture_check(link1_picture_check),
    .link2_picture_check(link2_picture_check),
    .link1_luma_anc_err(link1_luma_anc_err),
    .link1_chroma_anc_err(link1_chroma_anc_err),
    .link2_luma_anc_err(link2_luma_anc_err),
    .link2_chroma_anc_err(link2_chroma_anc_err),
    .trig_event(trig_event)
  );

  vfct_xfer u_xfer (
    .aclk(aclk),
    .aresetn(aresetn),
    .go(q.xs_go),
    .count(q.xs_count),
    .frame_done(xfer_frame_done),
    .busy(xf_busy),
    .done_frames(xf_done),
    .finished(xf_fin)
  );

  assign wmask = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
  assign wm = q.wdata & wmask;

  //////////////////////////////////////////////////////////////////////////////
  // next state: bus slave, then capture engine
  always_comb
  begin
    d = q;
    d.cmd = '0;
    d.xs_go = 1'b0;
    d.we = 1'b0;
    d.sof = 1'b0;
    // address and data may arrive in either order
    if (s_axi_awvalid && q.awready)
    begin
      d.aw_have = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    // commit once both halves are held and no response is pending
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `VFCT_RESP_OKAY;
      unique case (q.awaddr)
        `VFCT_CTRL_OFS: d.cmd = wm[`VFCT_CMD_W-1:0];
        `VFCT_TRIG_EN_OFS: d.trig_en = (q.trig_en & ~wmask[11:0]) | wm[11:0];
        `VFCT_POS_OFS: d.pos = (q.pos & ~wmask[6:0]) | wm[6:0];
        `VFCT_CLIP_LEN_OFS: d.clip_len = (q.clip_len & ~wmask[6:0]) | wm[6:0];
        `VFCT_MODE_OFS:
        begin
          // the standard is only changed while idle; the ring depth depends on it
          if (q.st == st_idle && q.wstrb[0])
            d.hd = q.wdata[`VFCT_MODE_HD];
          if (q.wstrb[0])
            d.single = q.wdata[`VFCT_MODE_SINGLE];
        end
        `VFCT_STATUS_OFS, `VFCT_INDEX_OFS, `VFCT_PROGRESS_OFS: ;
        default: d.bresp = `VFCT_RESP_SLVERR;
      endcase
    end
    // read channel: one outstanding read
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && q.arready)
    begin
      d.rvalid = 1'b1;
      d.rresp = `VFCT_RESP_OKAY;
      d.rdata = '0;
      unique case (s_axi_araddr)
        `VFCT_CTRL_OFS: d.rdata = '0; // commands read back as zero
        `VFCT_TRIG_EN_OFS: d.rdata[11:0] = q.trig_en;
        `VFCT_POS_OFS: d.rdata[6:0] = q.pos;
        `VFCT_CLIP_LEN_OFS: d.rdata[6:0] = q.clip_len;
        `VFCT_MODE_OFS: d.rdata[1:0] = {q.single, q.hd};
        `VFCT_STATUS_OFS:
          d.rdata[6:0] = {q.trig_pend, q.at_trig, xf_busy, q.st == st_playing,
                          q.st == st_captured, q.st == st_record, q.filling};
        `VFCT_INDEX_OFS:
        begin
          d.rdata[`VFCT_IDX_CUR_LSB +: 7] = q.cur;
          d.rdata[`VFCT_IDX_TOTAL_LSB +: 7] = q.total;
          d.rdata[`VFCT_IDX_TRIG_LSB +: 7] = q.trig_idx;
        end
        `VFCT_PROGRESS_OFS: d.rdata[14:0] = {q.xs_count, 1'b0, xf_done};
        default: d.rresp = `VFCT_RESP_SLVERR;
      endcase
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;

    // record command restarts the ring from any settled state
    if (q.cmd[`VFCT_CMD_RECORD] && q.st != st_xfer)
    begin
      d.st = st_record;
      d.wr = '0;
      d.filled = '0;
      d.trig_pend = 1'b0;
    end
    else
    begin
      unique case (q.st)
        st_idle: ;
        st_record:
        begin
          // only the first trigger counts; later ones fall away
          if ((q.cmd[`VFCT_CMD_TRIGGER] || trig_event) && !q.trig_pend)
          begin
            d.trig_pend = 1'b1;
            d.tpos = (q.pos >= depth) ? 7'(depth - 7'h01) : q.pos;
            d.post_left = d.tpos;
          end
          if (vid_valid)
          begin
            d.we = 1'b1;
            d.slot = q.wr;
            d.data = vid_data;
            d.sof = vid_sof;
            if (vid_eof)
            begin
              d.wr = (q.wr == depth - 7'h01) ? 7'h00 : q.wr + 7'h01;
              if (q.filled != depth)
                d.filled = q.filled + 7'h01;
              if (q.trig_pend && q.post_left == 7'h00)
              begin
                // freeze: nothing is written after this frame
                d.st = st_captured;
                d.total = d.filled;
                d.start = (d.filled == depth) ? d.wr : 7'h00;
                d.trig_idx = (q.tpos >= d.filled) ? 7'h00 : 7'(d.filled - 7'h01 - q.tpos);
                d.cur = d.trig_idx;
              end
              else if (q.trig_pend)
                d.post_left = q.post_left - 7'h01;
            end
          end
        end
        st_captured:
        begin
          if (q.cmd[`VFCT_CMD_PLAY] && q.total != 7'h00)
            d.st = st_playing;
          else if (q.cmd[`VFCT_CMD_STEP_BACK] && q.cur != 7'h00)
            d.cur = q.cur - 7'h01;
          else if (q.cmd[`VFCT_CMD_STEP_FWD] && q.cur + 7'h01 < q.total)
            d.cur = q.cur + 7'h01;
          else if (q.cmd[`VFCT_CMD_SAVE])
          begin
            d.st = st_xfer;
            d.xs_go = 1'b1;
            d.xs_load = 1'b0;
            d.xs_base = q.single ? q.cur : 7'h00;
            d.xs_count = q.single ? 7'h01 : q.total;
          end
        end
        st_playing:
        begin
          if (q.cmd[`VFCT_CMD_STOP])
            d.st = st_captured;
          else if (vid_valid && vid_sof)
            d.cur = (q.cur + 7'h01 >= q.total) ? 7'h00 : q.cur + 7'h01;
        end
        st_xfer:
        begin
          if (xf_fin)
          begin
            d.st = st_captured;
            if (q.xs_load)
            begin
              // a restored clip starts at slot zero like a capture taken before the ring filled
              d.start = 7'h00;
              d.total = q.xs_count;
              d.cur = 7'h00;
              d.trig_idx = 7'h00;
            end
          end
        end
      endcase
      // load is accepted whenever the engine is idle, captured or playing
      if (q.cmd[`VFCT_CMD_LOAD] && (q.st == st_idle || q.st == st_captured
          || q.st == st_playing))
      begin
        d.st = st_xfer;
        d.xs_go = 1'b1;
        d.xs_load = 1'b1;
        d.xs_base = 7'h00;
        d.xs_count = (q.clip_len > depth) ? depth : q.clip_len;
      end
    end
    // registered status and pointers, following the new state; xslot follows the current state
    d.filling = (d.st == st_record) && (d.filled != depth);
    d.show = ring_add(d.start, d.cur, depth);
    d.at_trig = (d.st == st_captured || d.st == st_playing) && d.cur == d.trig_idx;
    d.xslot = q.xs_load ? xf_done : ring_add(q.start, 7'(q.xs_base + xf_done), depth);
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.st <= st_idle;
      q.trig_en <= `VFCT_TRIG_EN_RST;
      q.pos <= `VFCT_POS_RST;
      q.clip_len <= `VFCT_CLIP_LEN_RST;
    end
    else
      q <= d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register except xfer_active, from the transfer engine
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign store_we = q.we;
  assign store_slot = q.slot;
  assign store_data = q.data;
  assign store_sof = q.sof;
  assign show_slot = q.show;
  assign show_is_trigger = q.at_trig;
  assign xfer_active = xf_busy;
  assign xfer_is_load = q.xs_load;
  assign xfer_slot = q.xslot;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_frozen_buffer: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == st_captured) |=> !store_we)
    else $error("buffer written while captured");
  a_record_writes: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == st_record && vid_valid && !q.cmd[`VFCT_CMD_RECORD]) |=> store_we && store_data == $past(vid_data))
    else $error("recording dropped a word");
  a_filling_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    q.filling |-> (q.st == st_record && q.filled < depth))
    else $error("filling flag wrong");
  a_play_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == st_playing && vid_valid && vid_sof && !q.cmd[`VFCT_CMD_STOP]
     && !q.cmd[`VFCT_CMD_RECORD] && !q.cmd[`VFCT_CMD_LOAD] && q.cur == q.total - 7'h01)
    |=> q.cur == 7'h00)
    else $error("playback did not loop");
  a_stop_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == st_playing && q.cmd[`VFCT_CMD_STOP] && !q.cmd[`VFCT_CMD_RECORD] && !q.cmd[`VFCT_CMD_LOAD])
    |=> q.st == st_captured && q.cur == $past(q.cur))
    else $error("stop did not hold frame");
  a_step_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == st_captured && q.cmd == 8'h20 && q.cur + 7'h01 < q.total)
    |=> q.cur == $past(q.cur) + 7'h01)
    else $error("step forward wrong");
  a_trigger_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == st_captured) |-> ##1 (show_is_trigger == (q.cur == q.trig_idx) || q.st != st_captured))
    else $error("trigger flag mismatch");
  a_idle_ignores: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == st_idle && !q.cmd[`VFCT_CMD_RECORD] && trig_event) |=> q.st != st_captured)
    else $error("trigger acted on while idle");
endmodule // vfct_capture

/* dv/vfct_rx_model.sv */
`timescale 1ns/10ps
// receiver stand-in: frames of n words (caller's choice) and error flags on request
module vfct_rx_model (
  // clock
  input wire logic aclk,
  // video stream
  output vfct_pkg::vfct_word_t vid_data,
  output logic vid_valid,
  output logic vid_sof,
  output logic vid_eof,
  // error sources, bit order as trigger enables
  output logic [11:0] ev
);
  import vfct_pkg::*;
  initial {vid_valid, vid_sof, vid_eof, ev, vid_data} = '0;
  // one frame, words back to back
  task automatic send_frame(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge aclk);
      vid_valid <= 1'b1;
      vid_sof <= (i == 0);
      vid_eof <= (i == n - 1);
      vid_data <= vfct_word_t'($urandom);
    end
    @(posedge aclk);
    {vid_valid, vid_sof, vid_eof} <= '0;
    // stale word inverted so it never passes for live data
    vid_data <= ~vid_data;
  endtask
  // short flag pulse, rise then fall
  task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    repeat (2) @(posedge aclk);
    ev[i] <= 1'b0;
  endtask
endmodule // vfct_rx_model

/* dv/video_frame_capture_trigger_test.sv */
`timescale 1ns/10ps
`include "vfct_defs.svh"
module video_frame_capture_trigger_test;
  import vfct_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, xfer_frame_done = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp;
  vfct_word_t vid_data, store_data, pvd;
  logic vid_valid, vid_sof, vid_eof, store_we, store_sof, show_is_trigger, xfer_active;
  logic xfer_is_load, psof, peof;
  vfct_frame_t store_slot, show_slot, xfer_slot;
  logic [11:0] ev;
  logic edh_active_picture_flag, edh_full_field_flag, link1_luma_crc_err, link1_chroma_crc_err;
  logic link2_luma_crc_err, link2_chroma_crc_err, link1_luma_anc_err, link1_chroma_anc_err;
  logic link2_luma_anc_err, link2_chroma_anc_err;
  logic [15:0] link1_picture_check, link2_picture_check;
  // model state: clip length, trigger and current index
  int error_cnt = 0, checks_done = 0, cyc = 0, nst = 0, total, trg, cur, src, ws = 0;
  assign {link1_picture_check, link2_picture_check} = {15'h0, ev[6], 15'h0, ev[7]};
  assign {edh_full_field_flag, edh_active_picture_flag} = ev[1:0];
  assign {link2_chroma_crc_err, link2_luma_crc_err, link1_chroma_crc_err} = ev[5:3];
  assign link1_luma_crc_err = ev[2];
  assign {link2_chroma_anc_err, link2_luma_anc_err} = ev[11:10];
  assign {link1_chroma_anc_err, link1_luma_anc_err} = ev[9:8];
  vfct_capture vfct_capture_inst (.*);
  vfct_rx_model vfct_rx_model_inst (.*);
  initial forever #12.5 aclk = ~aclk;
  // stored words and hang guard
  always @(posedge aclk)
  begin
    // each stored word is last edge's word, slot counts frames since record
    if (store_we === 1'b1)
    begin
      nst++;
      chk({store_slot, store_sof, store_data}, {7'(ws), psof, pvd});
      if (peof) ws++;
    end
    {pvd, psof, peof} = {vid_data, vid_sof, vid_eof};
    if (++cyc == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end
  ////////////////////////////////////////
  task automatic summarize;
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    brsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // commands land one edge after commit
    repeat (4) @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {rdat, rrsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    // one quiet edge so a following read never reassigns rready at once
    @(posedge aclk);
  endtask
  task automatic cmd(input int b);
    if (b == `VFCT_CMD_RECORD) ws = 0;
    wr(`VFCT_CTRL_OFS, 32'h1 << b);
  endtask
  task automatic fr(input int n);
    repeat (n) vfct_rx_model_inst.send_frame(4);
    repeat (4) @(posedge aclk);
  endtask
  task automatic chk_st(input logic [31:0] m, input logic [31:0] e);
    rd(`VFCT_STATUS_OFS);
    chk(rdat & m, e);
  endtask
  task automatic chk_idx;
    rd(`VFCT_INDEX_OFS);
    chk(rdat, (trg << 16) | (total << 8) | cur);
    chk({show_is_trigger, show_slot}, {cur == trg, 7'(cur)});
  endtask
  task automatic fdone(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      xfer_frame_done <= 1'b1;
      @(posedge aclk);
      xfer_frame_done <= 1'b0;
    end
    repeat (4) @(posedge aclk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    src = $urandom(75);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(8'h40);
    chk({rdat, rrsp}, `VFCT_RESP_SLVERR);
    wr(8'h40, 32'h0);
    chk(brsp, `VFCT_RESP_SLVERR);
    // manual capture after four frames
    cmd(`VFCT_CMD_RECORD);
    chk_st(32'h3, 32'h3);
    fr(3);
    cmd(`VFCT_CMD_TRIGGER);
    fr(1);
    {total, trg, cur} = {32'd4, 32'd3, 32'd3};
    chk_st(32'h2e, 32'h24);
    chk_idx();
    chk(nst, 16);
    cmd(`VFCT_CMD_STEP_BACK);
    cur = 2;
    chk_idx();
    cmd(`VFCT_CMD_STEP_FWD);
    cmd(`VFCT_CMD_STEP_FWD);
    cur = 3;
    chk_idx();
    // playback wraps past the clip end
    cmd(`VFCT_CMD_PLAY);
    chk_st(32'h8, 32'h8);
    fr(2);
    cmd(`VFCT_CMD_STOP);
    cur = 1;
    chk_idx();
    chk_st(32'hc, 32'h4);
    // one random enabled source, its neighbour left disabled
    src = $urandom % 12;
    wr(`VFCT_TRIG_EN_OFS, 32'h1 << src);
    wr(`VFCT_POS_OFS, 32'h1);
    cmd(`VFCT_CMD_RECORD);
    fr(1);
    vfct_rx_model_inst.pulse(src ^ 1);
    fr(1);
    chk_st(32'h6, 32'h2);
    vfct_rx_model_inst.pulse(src);
    fr(2);
    {total, trg, cur} = {32'd4, 32'd2, 32'd2};
    chk_st(32'h6, 32'h4);
    chk_idx();
    vfct_rx_model_inst.pulse(src);
    fr(1);
    chk_idx();
    // single-frame save, then a two-frame load
    wr(`VFCT_MODE_OFS, 32'h2);
    cmd(`VFCT_CMD_SAVE);
    rd(`VFCT_PROGRESS_OFS);
    chk(rdat, 32'h100);
    chk({xfer_active, xfer_is_load, xfer_slot}, 9'h102);
    fdone(1);
    chk_st(32'h14, 32'h4);
    wr(`VFCT_CLIP_LEN_OFS, 32'h2);
    cmd(`VFCT_CMD_LOAD);
    chk({xfer_active, xfer_is_load, xfer_slot}, 9'h180);
    fdone(2);
    {total, trg, cur} = {32'd2, 32'd0, 32'd0};
    chk_idx();
    summarize();
  end
endmodule // video_frame_capture_trigger_test
